// file: hdl/fai_flash_if.sv
// Implementation choices: the address map and the Wishbone slave port.
`include "fai_regs.svh"

// Functional notes
// R1: wide mode: 32-bit fetch, 64-bit macro read
// R2: wide mode refuses every flash write
// R3: 32-bit mode: one 32-bit macro access
// R4: 16-bit mode: reads and writes as halfwords
// R5: 16-bit mode forbids instruction fetch
// R6: software sets read timing per frequency
// R7: software sets write timing per frequency
// R8: small-sector cpu to macro address mapping
// R9: large-sector cpu to macro address mapping
// R10: programmer adds offset via address bit 21
// R11: strap 111 at reset: halt, route pins
// R12: programming mode exposes macro as standalone part
// R13: programmer keeps addr bit0 low, bit20 high
// R14: width select tied high in cpu mode
// R15: programmer handles A19 pin per variant
// R16: security vector read from 0x148000 at boot
// R17: mode switch done by boot rom routine
// R18: programmer waits after reset before access
// R19: timing fields applied to every access; boot vector reads use only the rtime wait count
module fai_flash_if
	import fai_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// cpu flash port
	input  wire logic        cpu_req_i,
	input  wire logic        cpu_we_i,
	input  wire logic        cpu_fetch_i,
	input  wire logic [23:0] cpu_addr_i,
	input  wire logic [15:0] cpu_wdata_i,
	output logic      [31:0] cpu_rdata_o,
	output logic             cpu_ack_o,
	output logic             cpu_err_o,
	output logic             cpu_halt_o,
	// pins and strap
	input  wire logic [2:0]  boot_mode_pins_i,
	input  wire logic        ext_prog_reset_i,
	input  wire logic        ext_write_strobe_i,
	input  wire logic        ext_output_enable_i,
	input  wire logic        ext_chip_select_i,
	input  wire logic [21:0] ext_macro_address_i,
	input  wire logic [15:0] ext_dq_i,
	output logic      [15:0] ext_dq_o,
	output logic             ext_dq_oe_n_o,
	output logic             ext_ready_busy_o,
	output logic             sec_valid_o,
	output logic [127:0]     sec_vector_o,
	// flash macro
	output logic      [21:0] macro_address_o,
	output logic      [63:0] macro_wdata_o,
	input  wire logic [63:0] macro_rdata_i,
	input  wire logic        macro_ready_busy_i,
	output logic             macro_reset_pin_o,
	output logic             chip_select_in_o,
	output logic             output_enable_in_o,
	output logic             write_strobe_in_o,
	output logic             width_select_in_o,
	output logic             transition_detect_in_o,
	output logic             balance_in_o,
	output logic             latch_hold_o,
	output logic [1:0]       access_width_o
);

	// ***************************************************************
	// state
	// ***************************************************************
	typedef struct packed {
		fai_state_t  st;
		logic [1:0]  mode;
		logic        big;
		logic [15:0] rtime;
		logic [15:0] wtime;
		logic [23:0] xin;
		logic [3:0]  cnt;
		logic [1:0]  vidx;
		logic [127:0] vec;
		logic        vdone;
		logic        prog;
		logic        ack;
		logic [31:0] dat;
		logic        cack;
		logic        cerr;
		logic [31:0] crd;
		logic        refused;
		logic [2:0]  md_s1;
		logic [2:0]  md_s2;
	} fai_reg_t;

	fai_reg_t r;
	fai_reg_t next_r;

	// ***************************************************************
	// address mapping
	// ***************************************************************
	function automatic logic [23:0] fai_map(input logic [23:0] a,
		input logic big_var);
		logic [23:0] f;
		logic [23:0] lo;
		f = a;
		if (a >= `FAI_SMALL_LO) begin // R8
			lo = a & (`FAI_SMALL_SPAN - 24'h1);
			f  = a - lo + (lo >> 1);
			if (a[2])
				f = f + `FAI_SMALL_ODD;
			f = f - {22'h0, a[2:1]} + {22'h0, a[1:0]};
			f = f - (big_var ? `FAI_SMALL_BASE_L : `FAI_SMALL_BASE_S);
		end else begin // R9
			lo = a & (`FAI_BIG_SPAN - 24'h1);
			f  = a - lo + (lo >> 1);
			if (a[2])
				f = f + `FAI_BIG_ODD;
			f = f - {22'h0, a[2:1]} + {22'h0, a[1:0]};
			if (big_var)
				f = f + `FAI_BIG_ADD_L;
		end
		return f;
	endfunction

	function automatic logic fai_mapped(input logic [23:0] a,
		input logic big_var);
		if (big_var)
			return (a >= `FAI_BIG_LO_L && a < `FAI_BIG_HI) ||
				(a >= `FAI_SMALL_LO && a < `FAI_SMALL_HI);
		return (a >= `FAI_BIG_LO_S && a < `FAI_BIG_HI) ||
			(a >= `FAI_SMALL_LO_S && a < `FAI_SMALL_HI);
	endfunction

	logic [23:0] cpu_fa;
	logic        wb_hit;
	logic        bad_req;
	logic [3:0]  tim_wtc;
	logic [23:0] vec_fa;

	assign cpu_fa = fai_map(cpu_addr_i, r.big);
	assign vec_fa = fai_map(`FAI_SECVEC_ADDR +
		{20'h0, r.vidx, 2'h0}, r.big);
	assign wb_hit = wb_cyc_i && wb_stb_i && !r.ack;
	// refusals: writes in wide and 32-bit mode, fetches in halfword mode, unmapped addresses
	assign bad_req = (cpu_we_i && fai_mode_t'(r.mode) == FAI_MODE_W64) || // R2
		(cpu_fetch_i && fai_mode_t'(r.mode) == FAI_MODE_W16) || // R5
		(cpu_we_i && fai_mode_t'(r.mode) == FAI_MODE_W32) ||
		!fai_mapped(cpu_addr_i, r.big);
	assign tim_wtc = cpu_we_i ? r.wtime[`FAI_TIM_WTC_LSB +: 4]
		: r.rtime[`FAI_TIM_WTC_LSB +: 4]; // R19

	// ***************************************************************
	// next state
	// ***************************************************************
	always_comb begin
		next_r         = r;
		next_r.md_s1   = boot_mode_pins_i;
		next_r.md_s2   = r.md_s1;
		next_r.ack     = 1'b0;
		next_r.cack    = 1'b0;
		next_r.cerr    = 1'b0;
		if (wb_hit) begin
			next_r.ack = 1'b1;
			next_r.dat = 32'h0;
			unique case (wb_adr_i)
			`FAI_OFF_CTRL:
				next_r.dat = {29'h0, r.big, r.mode};
			`FAI_OFF_RTIME:
				next_r.dat = {16'h0, r.rtime};
			`FAI_OFF_WTIME:
				next_r.dat = {16'h0, r.wtime};
			`FAI_OFF_STATUS:
				next_r.dat = {27'h0, r.refused, macro_ready_busy_i,
					r.vdone, r.prog, r.st == FAI_ST_IDLE};
			`FAI_OFF_XLATE_IN:
				next_r.dat = {8'h0, r.xin};
			`FAI_OFF_XLATE_OUT:
				next_r.dat = {8'h0, fai_map(r.xin, r.big)};
			default:
				next_r.dat = 32'h0;
			endcase
			if (wb_we_i && wb_sel_i[0]) begin
				unique case (wb_adr_i)
				`FAI_OFF_CTRL: begin
					if (wb_dat_i[1:0] != 2'h2)
						next_r.mode = wb_dat_i[1:0];
					next_r.big = wb_dat_i[`FAI_CTRL_BIG_BIT];
				end
				`FAI_OFF_RTIME:
					next_r.rtime = wb_dat_i[15:0];
				`FAI_OFF_WTIME:
					next_r.wtime = wb_dat_i[15:0];
				`FAI_OFF_XLATE_IN:
					next_r.xin = wb_dat_i[23:0];
				default: ;
				endcase
			end
			// refused flag: a new refusal wins over the clear
			if (wb_we_i && wb_sel_i[0] && wb_adr_i == `FAI_OFF_STATUS &&
				wb_dat_i[4])
				next_r.refused = 1'b0;
		end
		unique case (r.st)
		FAI_ST_BOOT: begin
			if (r.md_s2 == `FAI_STRAP_PROG) begin
				next_r.prog = 1'b1; // R11
				next_r.st   = FAI_ST_PROG;
			end else begin
				next_r.st  = FAI_ST_VEC;
				next_r.cnt = r.rtime[`FAI_TIM_WTC_LSB +: 4];
			end
		end
		FAI_ST_VEC: begin // R16
			if (r.cnt != 4'h0) begin
				next_r.cnt = r.cnt - 4'h1;
			end else begin
				next_r.vec[{r.vidx, 5'h0} +: 32] = macro_rdata_i[31:0];
				next_r.vidx = r.vidx + 2'h1;
				next_r.cnt  = r.rtime[`FAI_TIM_WTC_LSB +: 4];
				if (r.vidx == 2'(`FAI_SECVEC_WORDS - 1)) begin
					next_r.vdone = 1'b1;
					next_r.st    = FAI_ST_IDLE;
				end
			end
		end
		FAI_ST_IDLE: begin
			if (cpu_req_i) begin
				if (bad_req) begin
					next_r.cerr    = 1'b1;
					next_r.refused = 1'b1;
					next_r.st      = FAI_ST_DONE;
				end else begin
					next_r.st  = FAI_ST_SETUP;
					next_r.cnt = tim_wtc;
				end
			end
		end
		FAI_ST_SETUP:
			next_r.st = FAI_ST_WAIT;
		FAI_ST_WAIT: begin
			if (r.cnt != 4'h0) begin
				next_r.cnt = r.cnt - 4'h1;
			end else begin
				next_r.cack = 1'b1;
				next_r.st   = FAI_ST_DONE;
				unique case (fai_mode_t'(r.mode))
				FAI_MODE_W64: // R1
					next_r.crd = cpu_addr_i[2] ? macro_rdata_i[31:0]
						: macro_rdata_i[63:32];
				FAI_MODE_W32: // R3
					next_r.crd = macro_rdata_i[31:0];
				default: // R4
					next_r.crd = {16'h0, macro_rdata_i[15:0]};
				endcase
			end
		end
		FAI_ST_DONE:
			if (!cpu_req_i)
				next_r.st = FAI_ST_IDLE;
		FAI_ST_PROG:
			next_r.st = FAI_ST_PROG; // R11
		default:
			next_r.st = FAI_ST_BOOT;
		endcase
	end

	// ***************************************************************
	// registers
	// ***************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r         <= '0;
			r.st      <= FAI_ST_BOOT;
			r.mode    <= 2'(`FAI_RST_CTRL);
			r.rtime   <= 16'(`FAI_RST_RTIME);
			r.wtime   <= 16'(`FAI_RST_WTIME);
			// strap sync keeps running so boot sees it at release
			r.md_s1   <= boot_mode_pins_i; // R11
			r.md_s2   <= r.md_s1;
		end else begin
			r <= next_r;
		end
	end

	// ***************************************************************
	// macro and pin drive
	// ***************************************************************
	logic in_acc;
	logic rd_sel;
	logic [15:0] tim;

	assign in_acc = r.st == FAI_ST_SETUP || r.st == FAI_ST_WAIT;
	assign rd_sel = !cpu_we_i;
	assign tim    = (in_acc && cpu_we_i) ? r.wtime : r.rtime; // R19

	always_comb begin
		if (r.prog) begin // R12
			macro_address_o        = ext_macro_address_i;
			macro_wdata_o          = {48'h0, ext_dq_i};
			macro_reset_pin_o      = ext_prog_reset_i;
			chip_select_in_o       = ext_chip_select_i;
			output_enable_in_o     = ext_output_enable_i;
			write_strobe_in_o      = ext_write_strobe_i;
			transition_detect_in_o = 1'b0;
			balance_in_o           = 1'b0;
			latch_hold_o           = 1'b0;
			access_width_o         = 2'h0;
		end else begin
			macro_address_o        = r.st == FAI_ST_VEC
				? vec_fa[21:0] : cpu_fa[21:0];
			macro_wdata_o          = {48'h0, cpu_wdata_i};
			macro_reset_pin_o      = 1'b1;
			chip_select_in_o       = !(in_acc || r.st == FAI_ST_VEC);
			output_enable_in_o     = !((in_acc && rd_sel) ||
				r.st == FAI_ST_VEC);
			// strobe-high phase only when its field is set
			write_strobe_in_o      = !(r.st == FAI_ST_WAIT && cpu_we_i &&
				!(tim[`FAI_TIM_WRITE_STROBE_HIGH_CFG_BIT] && r.cnt == 4'h0));
			transition_detect_in_o = in_acc && tim[`FAI_TIM_ATD_BIT];
			balance_in_o           = in_acc &&
				(r.cnt < tim[`FAI_TIM_EQ_LSB +: 4]);
			latch_hold_o           = r.st == FAI_ST_SETUP &&
				tim[`FAI_TIM_LATCH_ENABLE_HOLD_CFG_BIT];
			access_width_o         = r.mode;
		end
	end

	assign width_select_in_o = 1'b1; // R14
	assign ext_dq_o          = macro_rdata_i[15:0];
	assign ext_dq_oe_n_o     = !(r.prog && !ext_output_enable_i &&
		!ext_chip_select_i);
	assign ext_ready_busy_o  = r.prog ? macro_ready_busy_i : 1'b1;
	assign cpu_halt_o        = r.prog;
	assign cpu_ack_o         = r.cack;
	assign cpu_err_o         = r.cerr;
	assign cpu_rdata_o       = r.crd;
	assign wb_ack_o          = r.ack;
	assign wb_dat_o          = r.dat;
	assign sec_valid_o       = r.vdone;
	assign sec_vector_o      = r.vec;

endmodule

// file: hdl/fai_pkg.sv
package fai_pkg;
	typedef enum logic [1:0] {
		FAI_MODE_W64 = 2'h0,
		FAI_MODE_W32 = 2'h1,
		FAI_MODE_W16 = 2'h3
	} fai_mode_t;

	typedef enum logic [2:0] {
		FAI_ST_BOOT  = 3'h0,
		FAI_ST_VEC   = 3'h1,
		FAI_ST_IDLE  = 3'h3,
		FAI_ST_SETUP = 3'h2,
		FAI_ST_WAIT  = 3'h6,
		FAI_ST_DONE  = 3'h7,
		FAI_ST_PROG  = 3'h5
	} fai_state_t;
endpackage

// file: hdl/fai_regs.svh
`ifndef FAI_REGS_SVH
`define FAI_REGS_SVH

// ***************************************************************
// register map (byte addresses on the wishbone slave)
// ***************************************************************
`define FAI_OFF_CTRL      8'h00
`define FAI_OFF_RTIME     8'h04
`define FAI_OFF_WTIME     8'h08
`define FAI_OFF_STATUS    8'h0c
`define FAI_OFF_XLATE_IN  8'h10
`define FAI_OFF_XLATE_OUT 8'h14

// ***************************************************************
// field positions
// ***************************************************************
`define FAI_CTRL_MODE_LSB   0
`define FAI_CTRL_BIG_BIT    2
`define FAI_TIM_ATD_BIT     0
`define FAI_TIM_LATCH_ENABLE_HOLD_CFG_BIT    1
`define FAI_TIM_EQ_LSB      4
`define FAI_TIM_WRITE_STROBE_HIGH_CFG_BIT    8
`define FAI_TIM_WTC_LSB     12

// ***************************************************************
// reset values
// ***************************************************************
`define FAI_RST_CTRL   32'h0000_0001
`define FAI_RST_RTIME  32'h0000_4331
`define FAI_RST_WTIME  32'h0000_7001

// ***************************************************************
// address mapping constants
// ***************************************************************
`define FAI_SMALL_SPAN    24'h00_4000
`define FAI_SMALL_ODD     24'h00_2000
`define FAI_SMALL_BASE_S  24'h0d_0000
`define FAI_SMALL_BASE_L  24'h05_0000
`define FAI_BIG_SPAN      24'h02_0000
`define FAI_BIG_ODD       24'h01_0000
`define FAI_BIG_ADD_L     24'h0c_0000
`define FAI_SMALL_LO      24'h14_0000
`define FAI_SMALL_LO_S    24'h14_8000
`define FAI_BIG_LO_S      24'h0a_0000
`define FAI_BIG_LO_L      24'h04_0000
`define FAI_BIG_HI        24'h10_0000
`define FAI_SMALL_HI      24'h15_0000

// ***************************************************************
// strap and security vector
// ***************************************************************
`define FAI_STRAP_PROG    3'h7
`define FAI_SECVEC_ADDR   24'h14_8000
`define FAI_SECVEC_WORDS  4

`endif

// file: tb/fai_flash_if_bench.sv
`include "fai_regs.svh"
module fai_flash_if_bench
	import fai_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// bench
	// ****************************************
	logic         clk_i = 1'b0, rst_i = 1'b1;
	logic         wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0]   wb_adr_i = 8'h0;
	logic [3:0]   wb_sel_i = 4'h0;
	logic [31:0]  wb_dat_i = 32'h0;
	logic         cpu_req_i = 1'b0, cpu_we_i = 1'b0, cpu_fetch_i = 1'b0;
	logic [23:0]  cpu_addr_i = 24'h0;
	logic [15:0]  cpu_wdata_i = 16'h0, ext_dq_i = 16'h0, ext_dq_o;
	logic [2:0]   boot_mode_pins_i = 3'h0;
	logic         ext_prog_reset_i = 1'b1, ext_write_strobe_i = 1'b1;
	logic         ext_output_enable_i = 1'b1, ext_chip_select_i = 1'b1;
	logic [21:0]  ext_macro_address_i = 22'h0, macro_address_o;
	logic [31:0]  wb_dat_o, cpu_rdata_o, rd;
	logic [63:0]  macro_wdata_o, macro_rdata_i;
	logic [127:0] sec_vector_o;
	logic [1:0]   access_width_o;
	logic [5:0]   snap;
	logic [21:0]  fx;
	logic         wb_ack_o, cpu_ack_o, cpu_err_o, cpu_halt_o, err;
	logic         ext_dq_oe_n_o, ext_ready_busy_o, sec_valid_o;
	logic         macro_ready_busy_i, macro_reset_pin_o, chip_select_in_o;
	logic         output_enable_in_o, write_strobe_in_o, width_select_in_o;
	logic         transition_detect_in_o, balance_in_o, latch_hold_o;
	int           fail_count = 0, checked = 0, lat;
	logic [24:0]  xt [8] = '{25'h0148000, 25'h014a006, 25'h014fffe,
		25'h00a0000, 25'h00f0005, 25'h1140004, 25'h1143ffa, 25'h10bfffe};
	logic [15:0]  rt [3] = '{16'h1000, 16'h2010, 16'h4331};
	fai_flash_if dut_u (.*);
	fai_macro_model macro_u (.clk_i(clk_i),
		.macro_address_i(macro_address_o), .chip_select_n_i(chip_select_in_o),
		.macro_rdata_o(macro_rdata_i), .ready_busy_o(macro_ready_busy_i));
	initial forever #5 clk_i = ~clk_i;
	function automatic logic [21:0] xlate(input logic [23:0] a,
		input logic big);
		logic [23:0] span, r;
		span = (a >= 24'h140000) ? 24'h004000 : 24'h020000;
		r = a - a % span + (a % span) / 2 + (a[2] ? span / 2 : 24'h0)
			- (a / 2) % 4 + a % 4;
		if (a >= 24'h140000)
			r = r - (big ? 24'h050000 : 24'h0d0000);
		else if (big)
			r = r + 24'h0c0000;
		return r[21:0];
	endfunction
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		if (fail_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wb_xfer(logic we, logic [7:0] adr, logic [31:0] dat);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= 4'hf;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic cpu_op(logic we, logic fetch, logic [23:0] a);
		cpu_req_i   <= 1'b1;
		cpu_we_i    <= we;
		cpu_fetch_i <= fetch;
		cpu_addr_i  <= a;
		cpu_wdata_i <= a[15:0];
		lat = -1;
		snap = 6'h0;
		do begin
			@(posedge clk_i);
			lat++;
			if (lat == 1)
				snap[3:0] = {latch_hold_o, transition_detect_in_o,
					output_enable_in_o, chip_select_in_o};
			if (lat == 2)
				snap[4] = write_strobe_in_o;
			snap[5] = snap[5] | balance_in_o;
		end while (cpu_ack_o !== 1'b1 && cpu_err_o !== 1'b1);
		rd  = cpu_rdata_o;
		err = cpu_err_o;
		cpu_req_i <= 1'b0;
		@(posedge clk_i);
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check("width", {31'h0, width_select_in_o}, 32'h1);
		wb_xfer(1'b0, `FAI_OFF_CTRL, 32'h0);
		check("ctrl", rd, 32'h1);
		wb_xfer(1'b0, `FAI_OFF_RTIME, 32'h0);
		check("rtime", rd, 32'h4331);
		wb_xfer(1'b0, `FAI_OFF_WTIME, 32'h0);
		check("wtime", rd, 32'h7001);
		wb_xfer(1'b0, 8'h1c, 32'h0);
		check("unmapped", rd, 32'h0);
		do wb_xfer(1'b0, `FAI_OFF_STATUS, 32'h0); while (rd[0] !== 1'b1);
		check("sec_valid", {31'h0, sec_valid_o}, 32'h1);
		for (int i = 0; i < 4; i++)
			check("secvec", sec_vector_o[32*i +: 32],
				{10'h2a5, xlate(24'h148000 + 24'(4 * i), 1'b0)});
		// a strap change after boot must not reach the pins
		boot_mode_pins_i    <= 3'h7;
		ext_chip_select_i   <= 1'b0;
		ext_output_enable_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		check("halt", {31'h0, cpu_halt_o}, 32'h0);
		check("dq_oe_n", {31'h0, ext_dq_oe_n_o}, 32'h1);
		ext_chip_select_i   <= 1'b1;
		ext_output_enable_i <= 1'b1;
		foreach (xt[i]) begin
			wb_xfer(1'b1, `FAI_OFF_CTRL, {29'h0, xt[i][24], 2'h1});
			wb_xfer(1'b1, `FAI_OFF_XLATE_IN, {8'h0, xt[i][23:0]});
			wb_xfer(1'b0, `FAI_OFF_XLATE_OUT, 32'h0);
			check("xlate", rd, {10'h0, xlate(xt[i][23:0], xt[i][24])});
		end
		wb_xfer(1'b1, `FAI_OFF_CTRL, 32'h1);
		foreach (rt[i]) begin
			wb_xfer(1'b1, `FAI_OFF_RTIME, {16'h0, rt[i]});
			cpu_op(1'b0, 1'b1, 24'h0a0004 + 24'(8 * i));
			check("rd_wait", 32'(lat), 32'(rt[i][15:12]) + 32'h3);
			check("rd_w32", rd,
				{10'h2a5, xlate(24'h0a0004 + 24'(8 * i), 1'b0)});
			check("rd_strobes", {26'h0, snap},
				{26'h0, |rt[i][7:4], 1'b1, rt[i][1:0], 2'h0});
		end
		wb_xfer(1'b1, `FAI_OFF_CTRL, 32'h0);
		cpu_op(1'b0, 1'b1, 24'h0c0010);
		check("rd_w64", rd, {10'h15a, xlate(24'h0c0010, 1'b0)});
		cpu_op(1'b0, 1'b1, 24'h0c0014);
		check("rd_w64_odd", rd, {10'h2a5, xlate(24'h0c0014, 1'b0)});
		cpu_op(1'b1, 1'b0, 24'h0c0010);
		check("w64_wr", {31'h0, err}, 32'h1);
		check("err_wait", 32'(lat), 32'h1);
		wb_xfer(1'b0, `FAI_OFF_STATUS, 32'h0);
		check("refused", {31'h0, rd[4]}, 32'h1);
		wb_xfer(1'b1, `FAI_OFF_STATUS, 32'h10);
		wb_xfer(1'b0, `FAI_OFF_STATUS, 32'h0);
		check("refused_clr", {31'h0, rd[4]}, 32'h0);
		wb_xfer(1'b1, `FAI_OFF_WTIME, 32'h3000);
		wb_xfer(1'b1, `FAI_OFF_CTRL, 32'h3);
		cpu_op(1'b0, 1'b1, 24'h0a0000);
		check("w16_fetch", {31'h0, err}, 32'h1);
		cpu_op(1'b1, 1'b0, 24'h0a0002);
		check("w16_wr", {31'h0, err}, 32'h0);
		check("wr_wait", 32'(lat), 32'h6);
		check("wr_strobes", {26'h0, snap}, 32'h2);
		cpu_op(1'b0, 1'b0, 24'h0a0002);
		check("w16_rd", {31'h0, err}, 32'h0);
		fx = xlate(24'h0a0002, 1'b0);
		check("w16_rdat", rd, {16'h0, fx[15:0]});
		wb_xfer(1'b1, `FAI_OFF_CTRL, 32'h2);
		wb_xfer(1'b0, `FAI_OFF_CTRL, 32'h0);
		check("mode_keep", rd, 32'h3);
		// second reset with the strap still at programming mode
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		ext_macro_address_i <= 22'h38_2468;
		ext_chip_select_i   <= 1'b0;
		ext_output_enable_i <= 1'b0;
		ext_prog_reset_i    <= 1'b0;
		@(posedge clk_i);
		check("prog_halt", {31'h0, cpu_halt_o}, 32'h1);
		check("prog_addr", {10'h0, macro_address_o}, 32'h38_2468);
		check("prog_dq", {16'h0, ext_dq_o}, 32'h2468);
		check("prog_oe_n", {31'h0, ext_dq_oe_n_o}, 32'h0);
		check("prog_rst", {31'h0, macro_reset_pin_o}, 32'h0);
		results();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		results();
	end
endmodule
bind fai_flash_if fai_flash_if_properties chk_u (.*);

// file: tb/fai_flash_if_properties.sv
`include "fai_regs.svh"
module fai_flash_if_properties
	import fai_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	input wire logic        cpu_req_i,
	input wire logic        cpu_we_i,
	input wire logic        cpu_fetch_i,
	input wire logic        cpu_ack_o,
	input wire logic        cpu_err_o,
	input wire logic        cpu_halt_o,
	input wire logic        ext_dq_oe_n_o,
	input wire logic        ext_ready_busy_o,
	input wire logic        width_select_in_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// bus-side mirror of mode and read wait
	// ****************************************
	logic [1:0] mode;
	logic [3:0] rwtc;
	logic [4:0] age;
	logic       req_d;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode  <= 2'h1;
			rwtc  <= 4'h4;
			age   <= 5'h0;
			req_d <= 1'b0;
		end else begin
			req_d <= cpu_req_i;
			if (cpu_req_i && !req_d)
				age <= 5'h1;
			else if (cpu_req_i && age != 5'h1f)
				age <= age + 5'h1;
			// mirror lags the design by one edge; requests never overlap it
			if (wb_ack_o && wb_we_i && wb_sel_i[0]) begin
				if (wb_adr_i == `FAI_OFF_CTRL && wb_dat_i[1:0] != 2'h2)
					mode <= wb_dat_i[1:0];
				if (wb_adr_i == `FAI_OFF_RTIME)
					rwtc <= wb_dat_i[15:12];
			end
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_take;
		cpu_req_i && !req_d && !cpu_halt_o;
	endsequence
	sequence s_refuse;
		##1 cpu_err_o;
	endsequence
	chk_width_high: assert property (width_select_in_o)
		else $error("width select not high");
	chk_wide_write: assert property (
		s_take ##0 (cpu_we_i && mode == FAI_MODE_W64) |-> s_refuse)
		else $error("wide mode write not refused");
	chk_narrow_fetch: assert property (
		s_take ##0 (cpu_fetch_i && mode == FAI_MODE_W16) |-> s_refuse)
		else $error("narrow mode fetch not refused");
	chk_read_wait: assert property (
		cpu_ack_o && !cpu_we_i |-> age == {1'b0, rwtc} + 5'h3)
		else $error("read answer not at wait plus three");
	chk_err_delay: assert property (cpu_err_o |-> age == 5'h1)
		else $error("refusal not one cycle after take");
	chk_halt_quiet: assert property (
		cpu_halt_o |-> !cpu_ack_o && !cpu_err_o)
		else $error("cpu answered while halted");
	chk_halt_hold: assert property (cpu_halt_o |=> cpu_halt_o)
		else $error("halt dropped without reset");
	chk_ack_pulse: assert property (cpu_ack_o |=> !cpu_ack_o)
		else $error("cpu ack longer than one cycle");
	chk_cpu_pins: assert property (
		!cpu_halt_o |-> ext_dq_oe_n_o && ext_ready_busy_o)
		else $error("pins driven outside programming mode");
	chk_wb_answer: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer not a one-cycle ack");
endmodule

// file: tb/fai_macro_model.sv
module fai_macro_model (
	input  wire logic        clk_i,
	input  wire logic [21:0] macro_address_i,
	input  wire logic        chip_select_n_i,
	output logic      [63:0] macro_rdata_o,
	output logic             ready_busy_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// flash macro stand-in
	// ****************************************
	logic [63:0] churn = 64'h0;
	logic [31:0] word;
	logic [31:0] hi;
	always @(posedge clk_i)
		churn <= churn + 64'h9e37_79b9_7f4a_7c15;
	// word carries its own address, so a wrong mapping shows in the data
	assign word          = {10'h2a5, macro_address_i};
	// halves differ so a wrong half select in wide mode shows
	assign hi            = {10'h15a, macro_address_i};
	// deselected: churning pattern, never the last word
	assign macro_rdata_o = chip_select_n_i ? churn : {hi, word};
	assign ready_busy_o  = 1'b1;
endmodule
